// ===== rtl/byte_wide_port_io.sv
/*
 * Port 1 logic: output latch, driver select, pin drive and
 * register read path for byte and bit accesses.
 * Assumes pins and crossbar controls are synchronous to mclk.
 */
// What this block does
// - port register reached by byte or bit
// - writes land in output latch
// - plain reads return pin levels
// - read-modify-write reads latch, writes back
// - ANL ORL XRL JBC CPL INC DEC DJNZ
// - bit MOV CLR SETB read latch
// - unbonded port registers stay usable
// - weak pull-ups enabled after reset
`timescale 1ns/1ps
module byte_wide_port_io
    import port_io_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    input  wire port_io_pkg::sfr_req_t req,
    output logic [7:0]                 rdata,
    input  wire logic [7:0]            pin_in,
    output port_io_pkg::pin_drive_t    pin_drive,
    input  wire logic [7:0]            xbar_assigned,
    input  wire logic [7:0]            xbar_periph_out,
    input  wire logic                  weak_pullup_disable,
    output logic                       weak_pullup_en
);
    import port_io_pkg::*;

    logic [7:0] latch_q;
    logic [7:0] drv_sel_q;
    logic [7:0] rdata_q;
    logic [7:0] read_view;
    logic [7:0] drive_val;
    logic [7:0] wr_merge;
    logic       pullup_q;
    logic       hit_port;
    logic       hit_cfg;
    logic       reads_latch;
    rd_src_t    src;
    pin_drive_t drive_d;
    pin_drive_t drive_q;

    // ==========================================================
    // address decode and read source
    assign hit_port = (req.addr == ADDR_PORT1_LATCH_AND_PINS);
    assign hit_cfg  = (req.addr == ADDR_PORT1_DRIVER_SELECT);

    rmw_decode i_rmw_decode (
        .opcode      (req.opcode),
        .reads_latch (reads_latch)
    );

    always_comb begin
        if (hit_port && reads_latch) begin
            src = RD_LATCH;
        end else if (hit_port) begin
            src = RD_PINS;
        end else if (hit_cfg) begin
            src = RD_CFG;
        end else begin
            src = RD_NONE;
        end
    end

    always_comb begin
        case (src)
            RD_PINS:  read_view = pin_in;
            RD_LATCH: read_view = latch_q;
            RD_CFG:   read_view = drv_sel_q;
            RD_NONE:  read_view = READ_UNMAPPED;
            default:  read_view = READ_UNMAPPED;
        endcase
    end

    // ==========================================================
    // read data register
    // bit read in bit zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= READ_UNMAPPED;
        end else if (ce && req.rd) begin
            if (req.bit_op) begin
                rdata_q <= {7'h00, read_view[req.bit_idx]};
            end else begin
                rdata_q <= read_view;
            end
        end
    end
    assign rdata = rdata_q;

    // ==========================================================
    // write merge: a bit write only touches its own bit
    // bit write merges latch, or driver select for that register
    always_comb begin
        wr_merge = hit_cfg ? drv_sel_q : latch_q;
        if (req.bit_op) begin
            wr_merge[req.bit_idx] = req.wdata[0];
        end else begin
            wr_merge = req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            latch_q <= RESET_PORT1_LATCH;
        end else if (ce && req.wr && hit_port) begin
            latch_q <= wr_merge;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            drv_sel_q <= RESET_PORT1_DRIVER_SELECT;
        end else if (ce && req.wr && hit_cfg) begin
            drv_sel_q <= wr_merge;
        end
    end

    // ==========================================================
    // pin drive, one bit per pin
    // latch or crossbar value
    for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_pin
        assign drive_val[i] = xbar_assigned[i] ? xbar_periph_out[i]
                                               : latch_q[i];
        assign drive_d.out[i] = drive_val[i];
        assign drive_d.oe[i]  = (drv_sel_q[i] == DRV_PUSH_PULL) ?
                                1'b1 : ~drive_val[i];
    end

    // registered pad drive
    always_ff @(posedge mclk) begin
        if (rst) begin
            drive_q <= '0;
        end else if (ce) begin
            drive_q <= drive_d;
        end
    end
    assign pin_drive = drive_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            pullup_q <= 1'b1;
        end else if (ce) begin
            pullup_q <= ~weak_pullup_disable;
        end
    end
    assign weak_pullup_en = pullup_q;

    // ==========================================================
    // checks
    sequence s_plain_port_read;
        ce && req.rd && !req.bit_op && hit_port && !reads_latch;
    endsequence

    sequence s_latch_port_read;
        ce && req.rd && !req.bit_op && hit_port && reads_latch;
    endsequence

    // byte write to the port, then a cycle with no port write
    sequence s_byte_port_write;
        ce && req.wr && !req.bit_op && hit_port;
    endsequence

    sequence s_port_left_alone;
        ce && !(req.wr && hit_port);
    endsequence

    AST_PIN_READ: assert property (
        @(posedge mclk) disable iff (rst)
        s_plain_port_read |=> (rdata == $past(pin_in)))
        else $error("plain port read did not return pins");

    AST_LATCH_READ: assert property (
        @(posedge mclk) disable iff (rst)
        s_latch_port_read |=> (rdata == $past(latch_q)))
        else $error("rmw port read did not return latch");

    AST_BYTE_WRITE: assert property (
        @(posedge mclk) disable iff (rst)
        s_byte_port_write ##1 s_port_left_alone
        |=> (latch_q == $past(req.wdata, 2)))
        else $error("byte write not held in latch");

    AST_BIT_WRITE: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && req.wr && req.bit_op && hit_port)
        |=> (latch_q[$past(req.bit_idx)] == $past(req.wdata[0])))
        else $error("bit write did not reach latch bit");

    AST_RMW_DECODE: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && req.rd && !req.bit_op && hit_port &&
         (req.opcode == OP_DJNZ_DIR || req.opcode == OP_XRL_DIR_IMM))
        |=> (rdata == $past(latch_q)))
        else $error("arithmetic opcode read did not return latch");

    AST_BIT_DEST: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && req.rd && req.bit_op && hit_port &&
         (req.opcode == OP_CLR_BIT || req.opcode == OP_SETB_BIT))
        |=> (rdata == {7'h00, $past(latch_q[req.bit_idx])}))
        else $error("bit opcode read did not return latch bit");

    AST_OPEN_DRAIN: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && drv_sel_q == RESET_PORT1_DRIVER_SELECT)
        |=> ((pin_drive.oe & pin_drive.out) == 8'h00))
        else $error("open-drain pin driven high");

    AST_PIN_LEVEL: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && xbar_assigned == 8'h00)
        |=> (pin_drive.out == $past(latch_q)))
        else $error("pin drive differs from latch");

    AST_PULLUP_RESET: assert property (
        @(posedge mclk)
        $fell(rst) |-> weak_pullup_en)
        else $error("pull-ups not enabled after reset");

    AST_CFG_READ: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && req.rd && !req.bit_op && hit_cfg)
        |=> (rdata == $past(drv_sel_q)))
        else $error("driver select readback wrong");
endmodule

// ===== rtl/port_io_pkg.sv
/*
 * Shared constants and carriers for the byte-wide port block.
 * Assumes a byte-wide controller core that issues one special function
 * register access per cycle and tells the port its opcode.
 */
package port_io_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_PORT1_LATCH_AND_PINS = 8'h90;
    localparam logic [7:0] ADDR_PORT1_DRIVER_SELECT  = 8'hA5;
    localparam logic [7:0] RESET_PORT1_LATCH         = 8'hFF;
    localparam logic [7:0] RESET_PORT1_DRIVER_SELECT = 8'h00;
    localparam logic [7:0] READ_UNMAPPED             = 8'h00;
    localparam logic       DRV_OPEN_DRAIN            = 1'b0;
    localparam logic       DRV_PUSH_PULL             = 1'b1;
    localparam int         PORT_WIDTH                = 8;

    // ==========================================================
    // opcodes whose port access reads the latch
    localparam logic [7:0] OP_ANL_DIR_A   = 8'h52;
    localparam logic [7:0] OP_ANL_DIR_IMM = 8'h53;
    localparam logic [7:0] OP_ORL_DIR_A   = 8'h42;
    localparam logic [7:0] OP_ORL_DIR_IMM = 8'h43;
    localparam logic [7:0] OP_XRL_DIR_A   = 8'h62;
    localparam logic [7:0] OP_XRL_DIR_IMM = 8'h63;
    localparam logic [7:0] OP_JBC_BIT     = 8'h10;
    localparam logic [7:0] OP_CPL_BIT     = 8'hB2;
    localparam logic [7:0] OP_INC_DIR     = 8'h05;
    localparam logic [7:0] OP_DEC_DIR     = 8'h15;
    localparam logic [7:0] OP_DJNZ_DIR    = 8'hD5;
    localparam logic [7:0] OP_MOV_BIT_C   = 8'h92;
    localparam logic [7:0] OP_CLR_BIT     = 8'hC2;
    localparam logic [7:0] OP_SETB_BIT    = 8'hD2;

    // ==========================================================
    // one access from the core
    typedef struct packed {
        logic       rd;       // read strobe
        logic       wr;       // write strobe
        logic       bit_op;   // single-bit access
        logic [2:0] bit_idx;  // bit within byte
        logic [7:0] addr;     // register address
        logic [7:0] wdata;    // byte, or bit in wdata[0]
        logic [7:0] opcode;   // instruction doing the access
    } sfr_req_t;

    // pin drive toward the pads
    typedef struct packed {
        logic [7:0] out;      // level driven
        logic [7:0] oe;       // high while the pin is driven
    } pin_drive_t;

    typedef enum logic [1:0] {
        RD_PINS  = 2'b00,
        RD_LATCH = 2'b01,
        RD_CFG   = 2'b10,
        RD_NONE  = 2'b11
    } rd_src_t;
endpackage

// ===== rtl/rmw_decode.sv
/*
 * Opcode classifier: flags instructions whose port read
 * returns the output latch instead of the pins.
 * Assumes the opcode is stable while the access strobe is high.
 */
`timescale 1ns/1ps
module rmw_decode
    import port_io_pkg::*;
(
    input  wire logic [7:0] opcode,
    output logic            reads_latch
);
    // ==========================================================
    // classification
    // logic, arithmetic, jump and bit opcodes
    always_comb begin
        case (opcode)
            OP_ANL_DIR_A, OP_ANL_DIR_IMM,
            OP_ORL_DIR_A, OP_ORL_DIR_IMM,
            OP_XRL_DIR_A, OP_XRL_DIR_IMM,
            OP_JBC_BIT, OP_CPL_BIT,
            OP_INC_DIR, OP_DEC_DIR, OP_DJNZ_DIR: reads_latch = 1'b1;
            OP_MOV_BIT_C, OP_CLR_BIT, OP_SETB_BIT: reads_latch = 1'b1;
            default: reads_latch = 1'b0;
        endcase
    end
endmodule

// ===== verification/port_pin_model.sv
/*
 * Board-side model of the circuitry on the port 1 pins.
 * Assumes pin_drive and weak_pullup_en come from the port block.
 */
`timescale 1ns/1ps
module port_pin_model
    import port_io_pkg::*;
(
    input  wire logic                   mclk,
    input  wire port_io_pkg::pin_drive_t pin_drive,
    input  wire logic                   weak_pullup_en,
    input  wire logic [7:0]             ext_en,
    input  wire logic [7:0]             ext_val,
    output logic [7:0]                  pin_in
);
    // =========================================================
    // pin resolution
    logic [7:0] float_q = 8'h55;

    // pins with no driver, outside source or pull-up wander so no stale level reads as valid
    always_ff @(posedge mclk) begin
        float_q <= ~float_q;
    end

    // driver first, then outside source, then pull-up
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            if (pin_drive.oe[n]) begin
                pin_in[n] = pin_drive.out[n];
            end else if (ext_en[n]) begin
                pin_in[n] = ext_val[n];
            end else if (weak_pullup_en) begin
                pin_in[n] = 1'b1;
            end else begin
                pin_in[n] = float_q[n];
            end
        end
    end
endmodule

// ===== verification/byte_wide_port_io_tb_top.sv
/*
 * Self-checking bench for the port 1 block.
 * Assumes the pin model stands in for the board.
 */
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
    bad_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module byte_wide_port_io_tb_top;
    import port_io_pkg::*;
    localparam logic [7:0] PA = ADDR_PORT1_LATCH_AND_PINS;
    localparam logic [7:0] CA = ADDR_PORT1_DRIVER_SELECT;
    logic       mclk = 0, rst = 1, ce = 1, weak_pullup_disable = 0;
    sfr_req_t   req = '0;
    pin_drive_t pin_drive;
    logic [7:0] rdata, pin_in, xbar_assigned = 0, xbar_periph_out = 0;
    logic [7:0] ext_en = 0, ext_val = 0;
    logic       weak_pullup_en;
    int         bad_count = 0, num_checks = 0;
    logic [7:0] ops [14] = '{OP_ANL_DIR_A, OP_ANL_DIR_IMM, OP_ORL_DIR_A,
        OP_ORL_DIR_IMM, OP_XRL_DIR_A, OP_XRL_DIR_IMM, OP_JBC_BIT,
        OP_CPL_BIT, OP_INC_DIR, OP_DEC_DIR, OP_DJNZ_DIR, OP_MOV_BIT_C,
        OP_CLR_BIT, OP_SETB_BIT};

    always #12.5 mclk = ~mclk;

    byte_wide_port_io i_byte_wide_port_io (.mclk(mclk), .rst(rst),
        .ce(ce), .req(req), .rdata(rdata), .pin_in(pin_in),
        .pin_drive(pin_drive), .xbar_assigned(xbar_assigned),
        .xbar_periph_out(xbar_periph_out),
        .weak_pullup_disable(weak_pullup_disable),
        .weak_pullup_en(weak_pullup_en));
    port_pin_model i_port_pin_model (.mclk(mclk), .pin_drive(pin_drive),
        .weak_pullup_en(weak_pullup_en), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    // =========================================================
    // access tasks
    task automatic acc(input logic r, w, b, input logic [2:0] i,
                       input logic [7:0] a, d, op);
        @(posedge mclk);
        req <= '{r, w, b, i, a, d, op};
        @(posedge mclk);
        req.rd <= 1'b0;
        req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a, op,
                          input logic b, input logic [2:0] i,
                          input logic [7:0] e);
        acc(1'b1, 1'b0, b, i, a, 8'h00, op);
        `CHK(n, e, rdata)
    endtask

    // write, then let the pin drive follow
    task automatic wr(input logic [7:0] a, d);
        acc(1'b0, 1'b1, 1'b0, 3'd0, a, d, 8'hF5);
        @(posedge mclk);
        #1;
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // =========================================================
    // watchdog
    initial begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        finish_test();
    end

    // =========================================================
    // test sequence
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        `CHK("pullup", 1'b1, weak_pullup_en)
        `CHK("oe rst", 8'h00, pin_drive.oe)
        `CHK("out rst", 8'hFF, pin_drive.out)
        rd_chk("pins rst", PA, 8'hE5, 0, 0, 8'hFF);
        rd_chk("cfg rst", CA, 8'hE5, 0, 0, 8'h00);
        rd_chk("unmapped", 8'h91, 8'hE5, 0, 0, READ_UNMAPPED);
        wr(PA, 8'h5A);
        `CHK("out", 8'h5A, pin_drive.out)
        `CHK("oe od", 8'hA5, pin_drive.oe)
        rd_chk("pins", PA, 8'hE5, 0, 0, 8'h5A);
        @(posedge mclk) ext_en <= 8'hFF;
        rd_chk("pin bit", PA, 8'hA2, 1, 1, 8'h00);
        rd_chk("latch bit", PA, OP_CLR_BIT, 1, 1, 8'h01);
        acc(1'b0, 1'b1, 1'b1, 3'd1, PA, 8'h00, OP_CLR_BIT);
        @(posedge mclk);
        #1;
        `CHK("bit wr", 8'h58, pin_drive.out)
        wr(PA, 8'hFF);
        foreach (ops[k]) begin
            if (ops[k] inside {OP_JBC_BIT, OP_CPL_BIT, OP_MOV_BIT_C,
                               OP_CLR_BIT, OP_SETB_BIT}) begin
                rd_chk("rmw bit", PA, ops[k], 1, 3, 8'h01);
            end else begin
                rd_chk("rmw byte", PA, ops[k], 0, 0, 8'hFF);
            end
        end
        rd_chk("pins low", PA, 8'hE5, 0, 0, 8'h00);
        @(posedge mclk) ext_en <= 8'h00;
        wr(CA, 8'hFF);
        wr(PA, 8'h3C);
        `CHK("oe pp", 8'hFF, pin_drive.oe)
        rd_chk("cfg", CA, 8'hE5, 0, 0, 8'hFF);
        @(posedge mclk) weak_pullup_disable <= 1'b1;
        @(posedge mclk);
        #1;
        `CHK("pullup off", 1'b0, weak_pullup_en)
        @(posedge mclk) xbar_assigned <= 8'h80;
        wr(PA, 8'hFF);
        `CHK("xbar out", 8'h7F, pin_drive.out)
        rd_chk("xbar pin", PA, 8'hE5, 0, 0, 8'h7F);
        rd_chk("xbar latch", PA, OP_ORL_DIR_A, 0, 0, 8'hFF);
        @(posedge mclk) ce <= 1'b0;
        acc(1'b0, 1'b1, 1'b0, 3'd0, PA, 8'h00, 8'hF5);
        @(posedge mclk) ce <= 1'b1;
        rd_chk("ce hold", PA, OP_ORL_DIR_A, 0, 0, 8'hFF);
        finish_test();
    end
endmodule
